// file: src/pao_pkg.sv
package pao_pkg;
  // Register word addresses on the bus
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_CLKCTL  = 8'h04;
  localparam logic [7:0] ADR_ACCL    = 8'h08;
  localparam logic [7:0] ADR_ACCH    = 8'h0C;
  localparam logic [7:0] ADR_ACCU    = 8'h10;
  localparam logic [7:0] ADR_INCL    = 8'h14;
  localparam logic [7:0] ADR_INCH    = 8'h18;
  localparam logic [7:0] ADR_INCU    = 8'h1C;
  localparam logic [7:0] ADR_IRQ_STS = 8'h20;
  localparam logic [7:0] ADR_IRQ_MSK = 8'h24;
  localparam logic [7:0] ADR_PIN     = 8'h28;
  // Control register fields
  localparam int CTRL_EN_BIT  = 7;
  localparam int CTRL_OUT_BIT = 5;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_PFM_BIT = 0;
  // Clock control fields
  localparam int CLK_PWS_LSB = 5;
  localparam int CLK_CKS_LSB = 0;
  // Interrupt and pin fields
  localparam int IRQ_OVF_BIT = 0;
  localparam int PIN_OE_BIT  = 0;
  // Clock source codes
  localparam logic [1:0] CKS_FAST_OSC = 2'h0;
  localparam logic [1:0] CKS_SYS_OSC  = 2'h1;
  localparam logic [1:0] CKS_LC3      = 2'h2;
  // Reset values
  localparam logic [7:0]  INCL_RST = 8'h01;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
  // Oscillator edges between low increment write and buffer load
  localparam int LOAD_TICKS = 2;
endpackage

// file: src/pao_osc.sv
// What this block does
// R1: Each selected-clock rising edge while enabled adds the buffered increment to the accumulator.
// R2: Accumulator is 20 bits, readable and writable as three byte registers.
// R3: Carry out of the addition is the raw overflow.
// R4: Every overflow sets the interrupt flag.
// R5: Increment is 20 bits in low, high and upper registers.
// R6: Software writes upper and high increment before low while enabled.
// R7: Enabled: low increment write loads buffers on second oscillator edge.
// R8: Disabled: any increment write loads buffers immediately.
// R9: Increment registers read and write; hidden buffers are not visible.
// R10: Adder advances only on selected oscillator clock edges.
// R11: Clock select picks fast oscillator, system oscillator or logic cell three.
// R12: Overflow is toggled or stretched, then sent to peripherals and pin.
// R13: Mode bit clear: output toggles on each overflow.
// R14: Mode bit set: output active right after overflow for pulse width.
// R15: Pulse width is 2 to the code input-clock periods, 1 to 128.
// R16: Clock select 00 fast, 01 system, 10 logic cell, 11 reserved.
// R17: Polarity bit inverts output; status bit shows resulting level.
// R18: Overflow rate is input rate times increment over two to twenty.
//
// Implementation choices: the address map and register access over Wishbone.
module pao_osc
  import pao_pkg::*;
#(
  parameter int ACC_W = 20
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        fast_internal_oscillator_i,
  input  wire logic        sys_osc_clk_i,
  input  wire logic        logic_cell_three_output_i,
  output logic             osc_out_o,
  output logic             pin_oe_o,
  output logic             irq_o
);
  localparam int UP_W = ACC_W - 16;

  if (ACC_W < 17 || ACC_W > 24) begin : g_bad_width
    $error("pao_osc: ACC_W must lie in 17..24");
  end

  logic             en;
  logic             pol;
  logic             pfm;
  logic [2:0]       pws;
  logic [1:0]       cks;
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] inc_reg;
  logic [ACC_W-1:0] inc_buf;
  logic             pend;
  logic             tick_seen;
  logic             src_q;
  logic             raw;
  logic [7:0]       pcnt;
  logic             sts;
  logic             msk;
  logic             ack;

  // Bus decode
  wire             req     = wb_cyc_i & wb_stb_i & ~ack;
  wire             wr      = req & wb_we_i & wb_sel_i[0];
  wire [7:0]       wd      = wb_dat_i[7:0];
  wire             wr_ctrl = wr && (wb_adr_i == ADR_CTRL);
  wire             wr_clk  = wr && (wb_adr_i == ADR_CLKCTL);
  wire             wr_accl = wr && (wb_adr_i == ADR_ACCL);
  wire             wr_acch = wr && (wb_adr_i == ADR_ACCH);
  wire             wr_accu = wr && (wb_adr_i == ADR_ACCU);
  wire             wr_incl = wr && (wb_adr_i == ADR_INCL);
  wire             wr_inch = wr && (wb_adr_i == ADR_INCH);
  wire             wr_incu = wr && (wb_adr_i == ADR_INCU);
  wire             wr_sts  = wr && (wb_adr_i == ADR_IRQ_STS);
  wire             wr_msk  = wr && (wb_adr_i == ADR_IRQ_MSK);
  wire             wr_pin  = wr && (wb_adr_i == ADR_PIN);
  wire             inc_wr  = wr_incl | wr_inch | wr_incu;

  // Clock source selection and edge detect
  wire src_sel = (cks == CKS_FAST_OSC) ? fast_internal_oscillator_i :
                 (cks == CKS_SYS_OSC)  ? sys_osc_clk_i :
                 (cks == CKS_LC3)      ? logic_cell_three_output_i : 1'b0; // R11 R16
  wire tick    = src_sel & ~src_q; // R10

  // Adder with carry
  wire [ACC_W:0] acc_sum = {1'b0, acc} + {1'b0, inc_buf}; // R1 R18
  wire           adv     = tick & en;
  wire           ovf_now = adv & acc_sum[ACC_W]; // R3

  // Next register values
  wire             next_en  = wr_ctrl ? wd[CTRL_EN_BIT] : en;
  wire             next_pol = wr_ctrl ? wd[CTRL_POL_BIT] : pol;
  wire             next_pfm = wr_ctrl ? wd[CTRL_PFM_BIT] : pfm;
  wire             next_msk = wr_msk ? wd[IRQ_OVF_BIT] : msk;
  wire             next_sts = (sts & ~(wr_sts & wd[IRQ_OVF_BIT])) | ovf_now; // R4
  wire [7:0]       width_m1 = 8'((9'h001 << pws) - 9'h001); // R15
  wire [ACC_W-1:0] next_acc;
  wire [ACC_W-1:0] next_inc;
  wire             next_raw;

  wire [ACC_W-1:0] acc_run = adv ? acc_sum[ACC_W-1:0] : acc; // R1
  assign next_acc = {wr_accu ? wd[UP_W-1:0] : acc_run[ACC_W-1:16],
                     wr_acch ? wd : acc_run[15:8],
                     wr_accl ? wd : acc_run[7:0]}; // R2
  assign next_inc = {wr_incu ? wd[UP_W-1:0] : inc_reg[ACC_W-1:16],
                     wr_inch ? wd : inc_reg[15:8],
                     wr_incl ? wd : inc_reg[7:0]}; // R5 R9

  // Output shaping
  wire pulse_end = raw & pfm & tick & (pcnt == width_m1);
  assign next_raw = !en                    ? 1'b0 :
                    (ovf_now && !pfm)      ? ~raw : // R13
                    (ovf_now && pfm)       ? 1'b1 : // R14
                    pulse_end              ? 1'b0 : // R15
                    !pfm                   ? raw :
                    raw;

  // Buffer load: second oscillator edge after low write, or at once if idle
  wire load_late = pend & tick & tick_seen & en; // R7
  wire load_now  = inc_wr & ~en; // R8

  // Read mux
  wire [31:0] rd_data =
    (wb_adr_i == ADR_CTRL)    ? {24'h00_0000, en, 1'b0, osc_out_o, pol, 3'h0, pfm} : // R17
    (wb_adr_i == ADR_CLKCTL)  ? {24'h00_0000, pws, 3'h0, cks} :
    (wb_adr_i == ADR_ACCL)    ? {24'h00_0000, acc[7:0]} :
    (wb_adr_i == ADR_ACCH)    ? {24'h00_0000, acc[15:8]} :
    (wb_adr_i == ADR_ACCU)    ? {{(32-UP_W){1'b0}}, acc[ACC_W-1:16]} :
    (wb_adr_i == ADR_INCL)    ? {24'h00_0000, inc_reg[7:0]} :
    (wb_adr_i == ADR_INCH)    ? {24'h00_0000, inc_reg[15:8]} :
    (wb_adr_i == ADR_INCU)    ? {{(32-UP_W){1'b0}}, inc_reg[ACC_W-1:16]} :
    (wb_adr_i == ADR_IRQ_STS) ? {31'h0000_0000, sts} :
    (wb_adr_i == ADR_IRQ_MSK) ? {31'h0000_0000, msk} :
    (wb_adr_i == ADR_PIN)     ? {31'h0000_0000, pin_oe_o} :
                                RD_ZERO;

  // Bus slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      wb_dat_o <= RD_ZERO;
    end else begin
      ack      <= req;
      wb_dat_o <= req ? rd_data : RD_ZERO;
    end
  end
  assign wb_ack_o = ack;

  // Configuration and interrupt registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en       <= 1'b0;
      pol      <= 1'b0;
      pfm      <= 1'b0;
      pws      <= 3'h0;
      cks      <= 2'h0;
      sts      <= 1'b0;
      msk      <= 1'b0;
      pin_oe_o <= 1'b0;
      irq_o    <= 1'b0;
    end else begin
      en    <= next_en;
      pol   <= next_pol;
      pfm   <= next_pfm;
      sts   <= next_sts;
      msk   <= next_msk;
      irq_o <= next_sts & next_msk;
      if (wr_clk) begin
        pws <= wd[CLK_PWS_LSB +: 3];
        cks <= wd[CLK_CKS_LSB +: 2];
      end
      if (wr_pin) begin
        pin_oe_o <= wd[PIN_OE_BIT]; // R12
      end
    end
  end

  // Accumulator and increment
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_q     <= 1'b0;
      acc       <= '0;
      inc_reg   <= ACC_W'(INCL_RST);
      inc_buf   <= ACC_W'(INCL_RST);
      pend      <= 1'b0;
      tick_seen <= 1'b0;
    end else begin
      src_q   <= src_sel;
      acc     <= next_acc;
      inc_reg <= next_inc;
      if (load_now) begin
        inc_buf <= next_inc; // R8
      end else if (load_late) begin
        inc_buf <= inc_reg; // R7
      end
      if (wr_incl && en) begin
        pend      <= 1'b1; // R6
        tick_seen <= 1'b0;
      end else if (load_late || load_now) begin
        pend      <= 1'b0;
        tick_seen <= 1'b0;
      end else if (pend && tick) begin
        tick_seen <= 1'b1;
      end
    end
  end

  // Output stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw       <= 1'b0;
      pcnt      <= 8'h00;
      osc_out_o <= 1'b0;
    end else begin
      raw       <= next_raw; // R12
      osc_out_o <= next_raw ^ next_pol; // R17
      if (ovf_now) begin
        pcnt <= 8'h00;
      end else if (raw && pfm && tick) begin
        pcnt <= pcnt + 8'h01; // R15
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_low_write_enabled;
    wr_incl && en && !pend;
  endsequence
  sequence s_first_tick;
    pend && tick && !tick_seen && en && !inc_wr;
  endsequence

  a_acc_adds: assert property ((adv && !wr_accl && !wr_acch && !wr_accu) |=> // R1
    acc == $past(acc_sum[ACC_W-1:0]))
    else $error("accumulator did not add increment");
  a_acc_hold: assert property ((!adv && !wr_accl && !wr_acch && !wr_accu) |=> // R10
    $stable(acc))
    else $error("accumulator moved without oscillator edge");
  a_carry_irq: assert property ((adv && acc_sum[ACC_W] && !wr_sts) |=> // R3 R4
    sts && irq_o == msk)
    else $error("overflow did not set flag");
  a_inc_now: assert property ((inc_wr && !en) |=> inc_buf == inc_reg) // R8
    else $error("idle increment write not loaded");
  a_inc_hold: assert property (s_low_write_enabled |=> // R7
    $stable(inc_buf) && pend)
    else $error("buffer loaded too early");
  a_inc_second: assert property ((pend && tick && tick_seen && en && !inc_wr) |=> // R7
    inc_buf == $past(inc_reg) && !pend)
    else $error("buffer not loaded on second edge");
  a_first_edge: assert property (s_first_tick |=> tick_seen && pend) // R7
    else $error("first oscillator edge not counted");
  a_fdc_toggle: assert property ((ovf_now && !pfm) |=> raw != $past(raw)) // R13
    else $error("fixed duty output did not toggle");
  a_pf_start: assert property ((ovf_now && pfm) |=> raw && pcnt == 8'h00) // R14
    else $error("pulse did not start after overflow");
  a_pf_end: assert property ((pulse_end && !ovf_now && en) |=> !raw) // R15
    else $error("pulse did not end at width");
  a_pol_level: assert property (osc_out_o == (raw ^ pol)) // R17
    else $error("output level ignores polarity");

  sequence s_pulse_wait;
    raw && pfm && en && !tick;
  endsequence
  sequence s_pulse_step;
    raw && pfm && en && tick && !ovf_now && !pulse_end;
  endsequence
  sequence s_fixed_quiet;
    en && !pfm && !ovf_now;
  endsequence
  sequence s_load_waiting;
    pend && en && !tick && !inc_wr;
  endsequence

  a_irq_level: assert property (irq_o == (sts && msk)) // R4
    else $error("interrupt level differs from flag and mask");
  a_sts_hold: assert property ((sts && !wr_sts) |=> sts) // R4
    else $error("overflow flag lost without clear");
  a_sts_clear: assert property ((wr_sts && wd[IRQ_OVF_BIT] && !ovf_now) |=> // R4
    !sts)
    else $error("overflow flag not cleared by write");
  a_off_idle: assert property (!en |=> !raw) // R12
    else $error("disabled block drives active output");
  a_fdc_hold: assert property (s_fixed_quiet |=> $stable(raw)) // R13
    else $error("fixed duty output moved without overflow");
  a_pf_hold: assert property (s_pulse_wait |=> raw) // R14
    else $error("pulse ended between oscillator edges");
  a_pf_count: assert property (s_pulse_step |=> // R15
    raw && pcnt == $past(pcnt) + 8'h01)
    else $error("pulse width counter did not advance");
  a_load_wait: assert property (s_load_waiting |=> // R7
    $stable(inc_buf) && pend)
    else $error("buffer loaded without oscillator edge");
  a_rsvd_still: assert property ((cks != CKS_FAST_OSC && cks != CKS_SYS_OSC && // R16
    cks != CKS_LC3) |-> !tick)
    else $error("reserved clock select produced an edge");
  a_accl_write: assert property (wr_accl |=> acc[7:0] == $past(wd)) // R2
    else $error("accumulator low byte write lost");
  a_incl_write: assert property (wr_incl |=> inc_reg[7:0] == $past(wd)) // R5
    else $error("increment low byte write lost");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held longer than one cycle");
  a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == RD_ZERO)
    else $error("read data not zero outside acknowledge");
endmodule

// file: bench/pao_src_model.sv
module pao_src_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      fast_o,
  output logic      sys_o,
  output logic      lc3_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [9:0] cnt;

  // Sources stand low between bursts
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt <= 10'h000;
    end else begin
      cnt <= cnt + 10'h001;
    end
  end

  // Periods of 2, 4 and 8 system clocks
  assign fast_o = cnt[0];
  assign sys_o  = cnt[1];
  assign lc3_o  = cnt[2];
endmodule

// file: bench/tb_phase_accumulator_oscillator.sv
module tb_phase_accumulator_oscillator import pao_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, osc_out_o, pin_oe_o, irq_o;
  logic        fast, sys, lc3;
  logic        run = 1'b0;
  int          bad_count = 0;
  int          checked = 0;

  always #20 clk_i = ~clk_i;

  pao_osc i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fast_internal_oscillator_i(fast),
    .sys_osc_clk_i(sys), .logic_cell_three_output_i(lc3), .osc_out_o, .pin_oe_o,
    .irq_o);

  pao_src_model i_src (.clk_i, .rst_i, .run_i(run), .fast_o(fast), .sys_o(sys),
    .lc3_o(lc3));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h00_0000, e});
  endtask

  task automatic clr_acc();
    wr(ADR_ACCL, 8'h00);
    wr(ADR_ACCH, 8'h00);
    wr(ADR_ACCU, 8'h00);
  endtask

  // Runs the sources for n clocks, counting clocks with the output high
  task automatic burst(input int n, output int hi);
    hi = 0;
    @(posedge clk_i);
    run <= 1'b1;
    repeat (n) begin
      @(posedge clk_i);
      hi += int'(osc_out_o === 1'b1);
    end
    run <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic conclude();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(40 * 60_000);
    bad_count++;
    conclude();
  end

  initial begin
    int hi;
    static int ticks [4] = '{16, 8, 4, 0};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({29'h0, osc_out_o, pin_oe_o, irq_o}, 32'h0000_0000);
    rd(ADR_CTRL, 8'h00);
    rd(ADR_INCL, 8'h01);
    rd(ADR_CLKCTL, 8'h00);
    wr(ADR_INCH, 8'h5A);
    rd(ADR_INCH, 8'h5A);
    wr(ADR_ACCU, 8'hFF);
    rd(ADR_ACCU, 8'h0F);
    wr(ADR_INCU, 8'hFF);
    rd(ADR_INCU, 8'h0F);
    wr(8'h2C, 8'hFF);
    rd(8'h2C, 8'h00);
    wb_sel_i <= 4'hE;
    wr(ADR_IRQ_MSK, 8'h01);
    wb_sel_i <= 4'hF;
    rd(ADR_IRQ_MSK, 8'h00);
    wr(ADR_PIN, 8'h01);
    chk({31'h0, pin_oe_o}, 32'h0000_0001);
    // Source select, disabled load of a new increment
    wr(ADR_INCU, 8'h00);
    wr(ADR_INCH, 8'h00);
    wr(ADR_INCL, 8'h03);
    for (int c = 0; c < 4; c++) begin
      clr_acc();
      wr(ADR_CLKCTL, 8'(c));
      wr(ADR_CTRL, 8'h80);
      burst(32, hi);
      wr(ADR_CTRL, 8'h00);
      rd(ADR_ACCL, 8'(3 * ticks[c]));
    end
    // Enabled update loads the buffer on the second tick
    clr_acc();
    wr(ADR_CLKCTL, 8'h00);
    wr(ADR_CTRL, 8'h80);
    wr(ADR_INCU, 8'h00);
    wr(ADR_INCH, 8'h00);
    wr(ADR_INCL, 8'h05);
    burst(8, hi);
    rd(ADR_ACCL, 8'h10);
    wr(ADR_CTRL, 8'h00);
    // Overflow, interrupt and toggle
    wr(ADR_INCU, 8'h08);
    wr(ADR_INCH, 8'h00);
    wr(ADR_INCL, 8'h00);
    clr_acc();
    wr(ADR_IRQ_MSK, 8'h01);
    wr(ADR_CTRL, 8'h80);
    burst(4, hi);
    chk({30'h0, irq_o, osc_out_o}, 32'h0000_0003);
    rd(ADR_ACCU, 8'h00);
    rd(ADR_CTRL, 8'hA0);
    rd(ADR_IRQ_STS, 8'h01);
    wr(ADR_IRQ_STS, 8'h01);
    rd(ADR_IRQ_STS, 8'h00);
    chk({31'h0, irq_o}, 32'h0000_0000);
    wr(ADR_IRQ_MSK, 8'h00);
    burst(4, hi);
    chk({30'h0, irq_o, osc_out_o}, 32'h0000_0000);
    rd(ADR_IRQ_STS, 8'h01);
    wr(ADR_CTRL, 8'h90);
    rd(ADR_CTRL, 8'hB0);
    chk({31'h0, osc_out_o}, 32'h0000_0001);
    // Pulse width for every code
    wr(ADR_CTRL, 8'h00);
    wr(ADR_INCU, 8'h00);
    wr(ADR_INCH, 8'h10);
    for (int c = 0; c < 8; c++) begin
      clr_acc();
      wr(ADR_CLKCTL, 8'(c << 5));
      wr(ADR_CTRL, 8'h81);
      burst(800, hi);
      wr(ADR_CTRL, 8'h00);
      chk(32'(hi), 32'(2 << c));
    end
    conclude();
  end
endmodule
